// [fom_defs.svh]
// register indices, field positions and reset values of the
// fractional modulator and output register bank
// assumes byte address = 4 * index on a 32-bit register bus
`ifndef FOM_DEFS_SVH
`define FOM_DEFS_SVH

`define FOM_IDX_W 6
`define FOM_IDX_DIVIDER_ROUTE 6'h24
`define FOM_IDX_DEN_HIGH 6'h28
`define FOM_IDX_DEN_LOW 6'h29
`define FOM_IDX_SEED_HIGH 6'h2A
`define FOM_IDX_SEED_LOW 6'h2B
`define FOM_IDX_NUM_HIGH 6'h2C
`define FOM_IDX_NUM_LOW 6'h2D
`define FOM_IDX_CONTROL 6'h2E
`define FOM_IDX_SOURCE_LEVEL 6'h2F
`define FOM_IDX_STATUS 6'h30

`define FOM_NUM_SLOTS 9
`define FOM_SLOT_DIVIDER_ROUTE 4'h8
`define FOM_SLOT_DEN_HIGH 4'h0
`define FOM_SLOT_DEN_LOW 4'h1
`define FOM_SLOT_SEED_HIGH 4'h2
`define FOM_SLOT_SEED_LOW 4'h3
`define FOM_SLOT_NUM_HIGH 4'h4
`define FOM_SLOT_NUM_LOW 4'h5
`define FOM_SLOT_CONTROL 4'h6
`define FOM_SLOT_SOURCE_LEVEL 4'h7

`define FOM_DIV_A_EN_BIT 10
`define FOM_OUT_A_DRIVE_LEVEL_HI 13
`define FOM_OUT_A_DRIVE_LEVEL_LO 8
`define FOM_OUT_B_POWERDOWN_BIT 7
`define FOM_OUT_A_POWERDOWN_BIT 6
`define FOM_MOD_EN_BIT 5
`define FOM_ORDER_HI 2
`define FOM_ORDER_LO 0
`define FOM_OUTA_SRC_HI 12
`define FOM_OUTA_SRC_LO 11
`define FOM_OUT_B_DRIVE_LEVEL_HI 5
`define FOM_OUT_B_DRIVE_LEVEL_LO 0

`define FOM_RST_DIVIDER_ROUTE 16'h0400
`define FOM_RST_DEN_HALF 16'h03E8
`define FOM_RST_SEED_HALF 16'h0000
`define FOM_RST_NUM_HALF 16'h0000
`define FOM_RST_CONTROL 16'h0FA3
`define FOM_RST_SOURCE_LEVEL 16'h0000

`define FOM_LEVEL_NORMAL_MAX 6'h1F
`define FOM_LEVEL_BOOST_MIN 6'h30
`define FOM_ORDER_MAX 3'h4

`define FOM_ST_BOOST_A 0
`define FOM_ST_BOOST_B 1
`define FOM_ST_GAP_A 2
`define FOM_ST_GAP_B 3
`define FOM_ST_ORDER_BAD 4
`define FOM_ST_SRC_RESERVED 5
`define FOM_ST_NUM_NOT_BELOW 6
`define FOM_ST_OUT_A_ACTIVE 7

`endif

// [fom_drive_decode.sv]
// classifies one output buffer drive-level code
// assumes a plain code input from logic on the same clock
`timescale 1ns/1ns
module fom_drive_decode #(
    parameter int W = 6
) (
    input wire logic [W-1:0] code,
    input wire logic [W-1:0] normal_max,
    input wire logic [W-1:0] boost_min,
    output logic normal,
    output logic boost,
    output logic gap
);
    always_comb begin
        normal = (code <= normal_max);
        boost = (code >= boost_min); // R6
        gap = !normal && !boost;
    end
endmodule

// [fom_pkg.sv]
// types shared by the modulator and output register bank
// assumes fom_defs.svh sits in the include path
package fom_pkg;
`include "fom_defs.svh"

typedef enum logic [1:0] {
    FOM_RESP_OKAY = 2'h0,
    FOM_RESP_SLVERR = 2'h2
} fom_resp_e;

typedef enum logic [2:0] {
    FOM_ORDER_INTEGER = 3'h0,
    FOM_ORDER_FIRST = 3'h1,
    FOM_ORDER_SECOND = 3'h2,
    FOM_ORDER_THIRD = 3'h3,
    FOM_ORDER_FOURTH = 3'h4
} fom_order_e;

typedef enum logic [1:0] {
    FOM_SRC_DIVIDER = 2'h0,
    FOM_SRC_OSCILLATOR = 2'h1
} fom_src_e;

typedef logic [`FOM_NUM_SLOTS-1:0][15:0] fom_regs_t;

typedef struct packed {
    fom_regs_t regs;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [`FOM_IDX_W-1:0] aw_idx;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    fom_resp_e bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    fom_resp_e rresp;
    logic [7:0] status;
    logic out_a_from_divider;
    logic out_a_from_oscillator;
    logic out_a_boost;
    logic out_b_boost;
    logic integer_mode;
} fom_state_s;

endpackage

// [fom_regbank.sv]
// modulator seed, fractional numerator/denominator and output buffer
// control registers behind an AXI4-Lite slave
// assumes a single master, one write and one read in flight at most
// a write answers the cycle after its address and data are both held;
// a read answers the cycle after its address is taken
//
// Summary of operation
// R1: 32-bit modulator seed in two halves, upper first, both reset zero.
// R2: numerator upper sixteen bits held in own register, reset zero.
// R3: numerator lower sixteen bits held in following register, reset zero.
// R4: modulator enable bit 5 resets 1; order bits 2:0 reset 3.
// R5: drive levels: A bits 13:8 reset 15, B bits 5:0 reset 0.
// R6: drive codes 48 to 63 flag the extra boost range.
// R7: buffer A powers down when bit 6 set; resets powered up.
// R8: buffer B powers down when bit 7 set; resets powered down.
// R9: buffer A source bits 12:11: 0 divider, 1 oscillator, others reserved.
// R10: host writes unnamed bits with their default values.
// R11: 32-bit denominator in two halves, upper first, each reset 1000.
// R12: divider-to-A buffer enable resets 1, gates divider path to A.
// R13: host keeps numerator below denominator in fractional orders.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "fom_defs.svh"
module fom_regbank
    import fom_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] modulator_seed,
    output logic [31:0] fraction_numerator,
    output logic [31:0] fraction_denominator,
    output logic modulator_enable,
    output logic [2:0] modulator_order,
    output logic modulator_integer_mode,
    output logic [5:0] out_a_drive_level,
    output logic [5:0] out_b_drive_level,
    output logic out_a_boost,
    output logic out_b_boost,
    output logic out_a_powerdown,
    output logic out_b_powerdown,
    output logic [1:0] out_a_source_select,
    output logic divider_to_out_a_enable,
    output logic out_a_from_divider,
    output logic out_a_from_oscillator
);

    fom_state_s q;
    fom_state_s d;

    logic a_normal;
    logic a_boost;
    logic a_gap;
    logic b_normal;
    logic b_boost;
    logic b_gap;
    logic [31:0] num_full;
    logic [31:0] den_full;
    logic [15:0] ctrl;
    logic [15:0] srcl;
    logic [2:0] order_f;
    logic [1:0] src_a_f;
    logic mod_en_f;
    logic div_a_en_f;

    // word index of a byte address; bits 1:0 are ignored
    function automatic logic [`FOM_IDX_W-1:0] idx_of(
        input logic [ADDR_W-1:0] addr
    );
        idx_of = addr[`FOM_IDX_W+1:2];
    endfunction

    function automatic logic is_reg(input logic [`FOM_IDX_W-1:0] idx);
        is_reg = (idx == `FOM_IDX_DIVIDER_ROUTE) ||
                 ((idx >= `FOM_IDX_DEN_HIGH) &&
                  (idx <= `FOM_IDX_SOURCE_LEVEL));
    endfunction

    function automatic logic [3:0] slot_of(
        input logic [`FOM_IDX_W-1:0] idx
    );
        logic [`FOM_IDX_W-1:0] off;
        off = idx - `FOM_IDX_DEN_HIGH;
        if (idx == `FOM_IDX_DIVIDER_ROUTE) begin
            slot_of = `FOM_SLOT_DIVIDER_ROUTE;
        end else begin
            slot_of = {1'b0, off[2:0]};
        end
    endfunction

    function automatic fom_regs_t regs_reset();
        fom_regs_t r;
        r = '0;
        r[`FOM_SLOT_DEN_HIGH] = `FOM_RST_DEN_HALF; // R11
        r[`FOM_SLOT_DEN_LOW] = `FOM_RST_DEN_HALF; // R11
        r[`FOM_SLOT_SEED_HIGH] = `FOM_RST_SEED_HALF; // R1
        r[`FOM_SLOT_SEED_LOW] = `FOM_RST_SEED_HALF; // R1
        r[`FOM_SLOT_NUM_HIGH] = `FOM_RST_NUM_HALF; // R2
        r[`FOM_SLOT_NUM_LOW] = `FOM_RST_NUM_HALF; // R3
        r[`FOM_SLOT_CONTROL] = `FOM_RST_CONTROL; // R4
        r[`FOM_SLOT_SOURCE_LEVEL] = `FOM_RST_SOURCE_LEVEL; // R9
        r[`FOM_SLOT_DIVIDER_ROUTE] = `FOM_RST_DIVIDER_ROUTE; // R12
        regs_reset = r;
    endfunction

    assign ctrl = q.regs[`FOM_SLOT_CONTROL];
    assign srcl = q.regs[`FOM_SLOT_SOURCE_LEVEL];
    assign num_full = {q.regs[`FOM_SLOT_NUM_HIGH],
                       q.regs[`FOM_SLOT_NUM_LOW]};
    assign den_full = {q.regs[`FOM_SLOT_DEN_HIGH],
                       q.regs[`FOM_SLOT_DEN_LOW]};

    // fields that the derived flags decode
    assign order_f = ctrl[`FOM_ORDER_HI:`FOM_ORDER_LO];
    assign src_a_f = srcl[`FOM_OUTA_SRC_HI:`FOM_OUTA_SRC_LO];
    assign mod_en_f = ctrl[`FOM_MOD_EN_BIT];
    assign div_a_en_f = q.regs[`FOM_SLOT_DIVIDER_ROUTE][`FOM_DIV_A_EN_BIT];

    fom_drive_decode #(
        .W(6)
    ) u_drive_a (
        .code(ctrl[`FOM_OUT_A_DRIVE_LEVEL_HI:`FOM_OUT_A_DRIVE_LEVEL_LO]),
        .normal_max(`FOM_LEVEL_NORMAL_MAX),
        .boost_min(`FOM_LEVEL_BOOST_MIN),
        .normal(a_normal),
        .boost(a_boost),
        .gap(a_gap)
    );

    fom_drive_decode #(
        .W(6)
    ) u_drive_b (
        .code(srcl[`FOM_OUT_B_DRIVE_LEVEL_HI:`FOM_OUT_B_DRIVE_LEVEL_LO]),
        .normal_max(`FOM_LEVEL_NORMAL_MAX),
        .boost_min(`FOM_LEVEL_BOOST_MIN),
        .normal(b_normal),
        .boost(b_boost),
        .gap(b_gap)
    );

    always_comb begin
        logic [3:0] ws;
        logic [3:0] rs;
        logic [`FOM_IDX_W-1:0] ridx;
        logic [15:0] cur;
        logic fractional;
        ws = slot_of(q.aw_idx);
        ridx = idx_of(s_axi_araddr);
        rs = slot_of(ridx);
        cur = q.regs[ws];
        fractional = 1'b0;
        d = q;

        // write address and data are taken independently
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_idx = idx_of(s_axi_awaddr);
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata[15:0];
            d.wstrb = s_axi_wstrb[1:0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // commit once both halves are held; upper data lanes are dropped
        if (q.aw_have && q.w_have && !q.bvalid) begin
            if (is_reg(q.aw_idx)) begin
                if (q.wstrb[0]) begin
                    cur[7:0] = q.wdata[7:0];
                end
                if (q.wstrb[1]) begin
                    cur[15:8] = q.wdata[15:8];
                end
                d.regs[ws] = cur; // R1 R2 R3 R11
                d.bresp = FOM_RESP_OKAY;
            end else begin
                d.bresp = FOM_RESP_SLVERR;
            end
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // read answers one cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            if (is_reg(ridx)) begin
                d.rdata = q.regs[rs];
                d.rresp = FOM_RESP_OKAY;
            end else if (ridx == `FOM_IDX_STATUS) begin
                d.rdata = {8'h00, q.status};
                d.rresp = FOM_RESP_OKAY;
            end else begin
                d.rdata = 16'h0000;
                d.rresp = FOM_RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;

        // derived controls, one cycle behind the register contents
        d.out_a_boost = a_boost; // R6
        d.out_b_boost = b_boost; // R6
        d.integer_mode = (order_f == FOM_ORDER_INTEGER) ||
                         !mod_en_f; // R4
        fractional = !d.integer_mode;
        // divider path also needs its distribution buffer
        d.out_a_from_divider =
            (src_a_f == FOM_SRC_DIVIDER) &&
            div_a_en_f; // R9 R12
        d.out_a_from_oscillator =
            (src_a_f == FOM_SRC_OSCILLATOR); // R9
        // status, read-only and one cycle behind the registers:
        // 0/1 buffer A/B code in the boost range, 2/3 in the unused gap,
        // 4 order code above fourth, 5 reserved buffer A source,
        // 6 numerator not below denominator in a fractional order,
        // 7 buffer A powered and fed from a valid path
        d.status = 8'h00;
        d.status[`FOM_ST_BOOST_A] = a_boost;
        d.status[`FOM_ST_BOOST_B] = b_boost;
        d.status[`FOM_ST_GAP_A] = a_gap && !a_normal;
        d.status[`FOM_ST_GAP_B] = b_gap && !b_normal;
        d.status[`FOM_ST_ORDER_BAD] =
            (ctrl[`FOM_ORDER_HI:`FOM_ORDER_LO] > `FOM_ORDER_MAX); // R4
        d.status[`FOM_ST_SRC_RESERVED] =
            srcl[`FOM_OUTA_SRC_HI]; // R9
        d.status[`FOM_ST_NUM_NOT_BELOW] =
            fractional && (num_full >= den_full); // R13
        d.status[`FOM_ST_OUT_A_ACTIVE] =
            !ctrl[`FOM_OUT_A_POWERDOWN_BIT] &&
            (d.out_a_from_divider || d.out_a_from_oscillator); // R7

        // derived flags except status bit 7 reset to what the reset register values imply
        if (!aresetn) begin
            d = '0;
            d.regs = regs_reset();
            d.bresp = FOM_RESP_OKAY;
            d.rresp = FOM_RESP_OKAY;
            d.out_a_from_divider = 1'b1;
            d.integer_mode = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = {16'h0000, q.rdata};
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;

    assign modulator_seed = {q.regs[`FOM_SLOT_SEED_HIGH],
                             q.regs[`FOM_SLOT_SEED_LOW]}; // R1
    assign fraction_numerator = num_full; // R2 R3
    assign fraction_denominator = den_full; // R11
    assign modulator_enable = ctrl[`FOM_MOD_EN_BIT]; // R4
    assign modulator_order = ctrl[`FOM_ORDER_HI:`FOM_ORDER_LO]; // R4
    assign modulator_integer_mode = q.integer_mode;
    assign out_a_drive_level =
        ctrl[`FOM_OUT_A_DRIVE_LEVEL_HI:`FOM_OUT_A_DRIVE_LEVEL_LO]; // R5
    assign out_b_drive_level =
        srcl[`FOM_OUT_B_DRIVE_LEVEL_HI:`FOM_OUT_B_DRIVE_LEVEL_LO]; // R5
    assign out_a_boost = q.out_a_boost;
    assign out_b_boost = q.out_b_boost;
    assign out_a_powerdown = ctrl[`FOM_OUT_A_POWERDOWN_BIT]; // R7
    assign out_b_powerdown = ctrl[`FOM_OUT_B_POWERDOWN_BIT]; // R8
    assign out_a_source_select =
        srcl[`FOM_OUTA_SRC_HI:`FOM_OUTA_SRC_LO]; // R9
    assign divider_to_out_a_enable =
        q.regs[`FOM_SLOT_DIVIDER_ROUTE][`FOM_DIV_A_EN_BIT]; // R12
    assign out_a_from_divider = q.out_a_from_divider;
    assign out_a_from_oscillator = q.out_a_from_oscillator;

endmodule

// [fom_regbank_checker.sv]
// concurrent checks on the register bank ports
// assumes a bind into fom_regbank with one clock domain
`timescale 1ns/1ns
module fom_regbank_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic modulator_enable,
    input wire logic [2:0] modulator_order,
    input wire logic modulator_integer_mode,
    input wire logic [5:0] out_a_drive_level,
    input wire logic [5:0] out_b_drive_level,
    input wire logic out_a_boost,
    input wire logic out_b_boost,
    input wire logic [1:0] out_a_source_select,
    input wire logic divider_to_out_a_enable,
    input wire logic out_a_from_divider,
    input wire logic out_a_from_oscillator
);
    logic up_q;
    always_ff @(posedge aclk) begin
        up_q <= aresetn;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_boost_a_range: assert property (up_q |->
        out_a_boost == ($past(out_a_drive_level) >= 6'h30))
        else $error("buffer A boost flag wrong");
    chk_boost_b_range: assert property (up_q |->
        out_b_boost == ($past(out_b_drive_level) >= 6'h30))
        else $error("buffer B boost flag wrong");
    chk_integer_mode: assert property (up_q |->
        modulator_integer_mode == ($past(modulator_order) == 3'h0
        || !$past(modulator_enable)))
        else $error("integer mode flag wrong");
    chk_divider_path: assert property (up_q |->
        out_a_from_divider == ($past(out_a_source_select) == 2'h0
        && $past(divider_to_out_a_enable)))
        else $error("divider path flag wrong");
    chk_osc_path: assert property (up_q |->
        out_a_from_oscillator == ($past(out_a_source_select) == 2'h1))
        else $error("oscillator path flag wrong");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer late or wide");
endmodule

bind fom_regbank fom_regbank_checker chk_u (.aclk(aclk),
    .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .modulator_enable(modulator_enable),
    .modulator_order(modulator_order),
    .modulator_integer_mode(modulator_integer_mode),
    .out_a_drive_level(out_a_drive_level),
    .out_b_drive_level(out_b_drive_level),
    .out_a_boost(out_a_boost), .out_b_boost(out_b_boost),
    .out_a_source_select(out_a_source_select),
    .divider_to_out_a_enable(divider_to_out_a_enable),
    .out_a_from_divider(out_a_from_divider),
    .out_a_from_oscillator(out_a_from_oscillator));

// [tb_top.sv]
// self-checking bench for the register bank
// assumes the checker is bound in and a 25 MHz clock
`timescale 1ns/1ns
module tb_top;
    logic aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_y, w_y, b_v;
    logic ar_y, r_v, en, imode, bsta, bstb, pda, pdb, dae, fdiv, fosc;
    logic [7:0] aw_a, ar_a;
    logic [31:0] w_d, r_d, seed, num, den;
    logic [1:0] b_rs, r_rs, sel;
    logic [2:0] ord;
    logic [5:0] lva, lvb;
    int mismatches, num_checks;
    fom_regbank dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_y), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_v), .s_axi_wready(w_y), .s_axi_bresp(b_rs),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
        .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v), .s_axi_arready(ar_y),
        .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .modulator_seed(seed),
        .fraction_numerator(num), .fraction_denominator(den),
        .modulator_enable(en), .modulator_order(ord),
        .modulator_integer_mode(imode), .out_a_drive_level(lva),
        .out_b_drive_level(lvb), .out_a_boost(bsta), .out_b_boost(bstb),
        .out_a_powerdown(pda), .out_b_powerdown(pdb),
        .out_a_source_select(sel), .divider_to_out_a_enable(dae),
        .out_a_from_divider(fdiv), .out_a_from_oscillator(fosc));
    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] re,
            int bd = 0);
        bit ad;
        bit wd;
        @(posedge aclk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= (bd == 0);
        ad = 0;
        wd = 0;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && aw_y) begin
                aw_v <= 1'b0;
                ad = 1;
            end
            if (!wd && w_y) begin
                w_v <= 1'b0;
                wd = 1;
            end
        end
        while (!b_v) @(posedge aclk);
        if (bd > 0) begin
            repeat (bd) @(posedge aclk);
            b_r <= 1'b1;
            @(posedge aclk);
        end
        b_r <= 1'b0;
        chk("bresp", b_rs, re);
    endtask
    task automatic rchk(string n, logic [7:0] a, logic [31:0] e,
            logic [1:0] re, int rd = 0);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= (rd == 0);
        do @(posedge aclk); while (!ar_y);
        ar_v <= 1'b0;
        while (!r_v) @(posedge aclk);
        if (rd > 0) begin
            repeat (rd) @(posedge aclk);
            r_r <= 1'b1;
            @(posedge aclk);
        end
        r_r <= 1'b0;
        chk(n, r_d, e);
        chk("rresp", r_rs, re);
    endtask
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task automatic t_reset();
        rchk("seed_hi", 8'hA8, 32'h0, 2'h0);
        rchk("seed_lo", 8'hAC, 32'h0, 2'h0);
        rchk("num_hi", 8'hB0, 32'h0, 2'h0);
        rchk("num_lo", 8'hB4, 32'h0, 2'h0);
        rchk("ctrl", 8'hB8, 32'h0FA3, 2'h0);
        rchk("srclv", 8'hBC, 32'h0, 2'h0);
        rchk("route", 8'h90, 32'h0400, 2'h0);
        chk("den", den, 32'h03E8_03E8);
        chk("ord", {en, ord}, 32'hB);
        chk("lvl", {lva, lvb}, 32'h3C0);
        chk("pd", {pda, pdb}, 32'h1);
        chk("sel", {sel, fdiv, fosc}, 32'h2);
        $display("test reset done");
    endtask
    task automatic t_rw();
        wr(8'hA8, 32'hABCD_1234, 2'h0);
        wr(8'hAC, 32'h0000_5678, 2'h0);
        wr(8'hB0, 32'h0000_0123, 2'h0);
        wr(8'hB4, 32'h0000_DEF0, 2'h0);
        chk("seed", seed, 32'h1234_5678);
        chk("num", num, 32'h0123_DEF0);
        rchk("seed_hi", 8'hA8, 32'h1234, 2'h0);
        rchk("num_lo", 8'hB4, 32'hDEF0, 2'h0);
        $display("test rw done");
    endtask
    task automatic t_ctrl();
        for (int o = 0; o < 5; o++) begin
            wr(8'hB8, 32'h20 | o, 2'h0);
            settle();
            chk("ord", ord, o);
            chk("imode", imode, o == 0);
        end
        wr(8'hB8, 32'h43, 2'h0);
        settle();
        chk("pd_a", {en, imode, pda, pdb}, 32'h6);
        wr(8'hB8, 32'hA3, 2'h0);
        settle();
        chk("pd_b", {pda, pdb}, 32'h1);
        $display("test ctrl done");
    endtask
    task automatic t_level();
        logic [5:0] c[5] = '{6'h1F, 6'h20, 6'h2F, 6'h30, 6'h3F};
        foreach (c[i]) begin
            wr(8'hB8, {18'h0, c[i], 8'h23}, 2'h0);
            wr(8'hBC, {26'h0, c[i]}, 2'h0);
            settle();
            chk("lvl", {lva, lvb}, {20'h0, c[i], c[i]});
            chk("boost", {bsta, bstb}, {2{c[i] >= 6'h30}});
        end
        for (int s = 0; s < 4; s++) begin
            wr(8'hBC, s << 11, 2'h0);
            settle();
            chk("src", {sel, fdiv, fosc}, {s[1:0], s == 0, s == 1});
        end
        wr(8'hBC, 32'h0, 2'h0);
        wr(8'h90, 32'h0, 2'h0);
        settle();
        chk("fdiv", {dae, fdiv}, 32'h0);
        $display("test level done");
    endtask
    task automatic t_err();
        wr(8'h00, 32'h1234, 2'h2);
        rchk("unmapped", 8'h00, 32'h0, 2'h2);
        wr(8'hC0, 32'hFF, 2'h2);
        rchk("den_hi", 8'hA0, 32'h03E8, 2'h0);
        wr(8'hAC, 32'h0000_4242, 2'h0, 3);
        rchk("stall", 8'hAC, 32'h4242, 2'h0, 3);
        rchk("status", 8'hC0, 32'h01, 2'h0);
        $display("test err done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        {aresetn, aw_v, w_v, b_r, ar_v, r_r} = 6'h0;
        {aw_a, ar_a, w_d} = 48'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_rw();
        t_ctrl();
        t_level();
        t_err();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        end_sim();
    end
endmodule
